// ==== bench/fmpm_core_bench.sv ====
/*
  Self-checking bench of the modulation core: registers, sample FIFO,
  FM, PM, PWM and keying. Assumes the package, design and model first.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    n_fail++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
  end \
end
module fmpm_core_bench;
  // ---------------------------------------------------------------------
  // Signals, model and core.
  // ---------------------------------------------------------------------
  localparam int DEPTH = 8;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic signed [15:0] ext_set = 16'sh0000;
  logic signed [15:0] chan_set = 16'sh0000;
  logic key_set = 1'b0;
  logic stall = 1'b0;
  logic hreadyout_o;
  logic [31:0] hrdata_o;
  logic signed [15:0] ext_mod_i;
  logic signed [15:0] chan_mod_i;
  logic trig_i;
  logic samp_valid_o;
  logic samp_ready_i;
  fmpm_pkg::fmpm_sample_s samp_data_o;
  fmpm_pkg::fmpm_sample_s q[$];
  int n_fail = 0;
  int checks_done = 0;

  // Clock of 5 ns period.
  always #2.5 mclk_i = ~mclk_i;

  fmpm_src_model fmpm_src_model_inst (.mclk_i(mclk_i), .stall_i(stall),
    .ext_set_i(ext_set), .chan_set_i(chan_set), .key_set_i(key_set),
    .ext_mod_o(ext_mod_i), .chan_mod_o(chan_mod_i), .trig_o(trig_i),
    .samp_ready_o(samp_ready_i));

  fmpm_core #(.FIFO_DEPTH(DEPTH)) fmpm_core_inst (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(), .hrdata_o(hrdata_o),
    .ext_mod_i(ext_mod_i), .chan_mod_i(chan_mod_i), .trig_i(trig_i),
    .samp_valid_o(samp_valid_o), .samp_ready_i(samp_ready_i),
    .samp_data_o(samp_data_o));

  // Every sample the sink takes is queued in order.
  always @(posedge mclk_i) begin
    if (samp_valid_o === 1'b1 && samp_ready_i === 1'b1 && ce_i && resetn_i)
      q.push_back(samp_data_o);
  end

  // ---------------------------------------------------------------------
  // Bus, helpers and scenarios.
  // ---------------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask

  // A write leaves one idle cycle so a following read sees the new value.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    ahb(1'b0, a, 32'h0000_0000, r);
  endtask

  function automatic logic [31:0] ctrl(input logic [2:0] t,
      input logic [1:0] s, input logic p);
    return {23'h000000, p, 2'h0, s, t, 1'b1};
  endfunction

  task automatic apply_reset();
    resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
  endtask

  // Lets a new setting settle, then collects n consecutive samples.
  task automatic grab(input int n);
    repeat (12) @(posedge mclk_i);
    q.delete();
    while (q.size() < n) @(posedge mclk_i);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    rd(fmpm_pkg::FMPM_CTRL_OFS, r);
    `CHK("ctrl reset", 32'h0000_0000, r)
    rd(fmpm_pkg::FMPM_PULSE_HI_OFS, r);
    `CHK("pulse reset", fmpm_pkg::FMPM_PULSE_HI_RST, r)
    wr(fmpm_pkg::FMPM_FM_DEV_OFS, 32'h1234_5678);
    rd(fmpm_pkg::FMPM_FM_DEV_OFS, r);
    `CHK("fm dev", 32'h1234_5678, r)
    wr(8'h24, 32'hFFFF_FFFF);
    rd(8'h24, r);
    `CHK("unmapped", 32'h0000_0000, r)
    $display("test regs done");
  endtask

  // Fills the FIFO against a stalled sink, then frees it and freezes; the
  // generator refills every slot the sink empties, so one stays free.
  task automatic t_fifo();
    logic [31:0] r;
    stall <= 1'b1;
    repeat (20) @(posedge mclk_i);
    rd(fmpm_pkg::FMPM_STATUS_OFS, r);
    `CHK("fifo full", 16'(DEPTH), r[15:0])
    `CHK("status amp", 1'b1, r[18])
    stall <= 1'b0;
    repeat (20) @(posedge mclk_i);
    ce_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    ce_i <= 1'b1;
    rd(fmpm_pkg::FMPM_STATUS_OFS, r);
    `CHK("fifo steady", 16'(DEPTH - 1), r[15:0])
    $display("test fifo done");
  endtask

  // Sets one mode and judges the field of the samples it acts on.
  task automatic mod_case(input logic [2:0] t, input logic [1:0] s,
      input logic p, input logic signed [15:0] e,
      input logic signed [15:0] c, input logic [15:0] ex);
    logic [15:0] got;
    ext_set <= e;
    chan_set <= c;
    key_set <= (e > 16'sh0000);
    wr(fmpm_pkg::FMPM_CTRL_OFS, ctrl(t, s, p));
    grab(2);
    case (t)
      3'h1: got = q[1].phase - q[0].phase;
      3'h2: got = q[0].phase;
      3'h3: got = {15'h0000, q[0].pulse};
      default: got = {15'h0000, q[0].amp_on};
    endcase
    `CHK("mod result", ex, got)
  endtask

  // Internal keying: 2*0x10000000 per sample toggles every 8 samples.
  task automatic t_key();
    int i;
    int hit;
    apply_reset();
    wr(fmpm_pkg::FMPM_KEY_INC_OFS, 32'h1000_0000);
    wr(fmpm_pkg::FMPM_CTRL_OFS, ctrl(3'h4, 2'h0, 1'b0));
    grab(40);
    hit = 0;
    for (i = 1; i < 24; i++) begin
      if (hit == 0 && q[i].amp_on !== q[i-1].amp_on) hit = i;
    end
    `CHK("key edge", 1'b1, hit > 0)
    `CHK("key run", q[hit].amp_on, q[hit+7].amp_on)
    `CHK("key toggle", ~q[hit].amp_on, q[hit+8].amp_on)
    $display("test keying done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    final_report();
  end

  // FM: carrier step 0x10, deviation step 0x4 in phase units.
  task automatic t_fm();
    wr(fmpm_pkg::FMPM_CAR_INC_OFS, 32'h0010_0000);
    wr(fmpm_pkg::FMPM_FM_DEV_OFS, 32'h0004_0000);
    mod_case(3'h1, 2'h2, 1'b0, 16'sh4000, 16'sh0, 16'h0014);
    mod_case(3'h1, 2'h1, 1'b0, 16'sh0, 16'sh2000, 16'h0012);
    mod_case(3'h1, 2'h2, 1'b0, 16'shC000, 16'sh0, 16'h000C);
    mod_case(3'h1, 2'h2, 1'b0, 16'sh7FFF, 16'sh0, 16'h0014);
    mod_case(3'h1, 2'h0, 1'b0, 16'sh0, 16'sh0, 16'h000C);
    $display("test fm done");
  endtask

  // PM from the external input and from the other channel.
  task automatic t_pm();
    apply_reset();
    wr(fmpm_pkg::FMPM_PM_DEV_OFS, 32'h2000_0000);
    mod_case(3'h2, 2'h2, 1'b0, 16'sh4000, 16'sh0, 16'h2000);
    mod_case(3'h2, 2'h2, 1'b0, 16'shC000, 16'sh0, 16'hE000);
    mod_case(3'h2, 2'h1, 1'b0, 16'sh0, 16'shE000, 16'hF000);
    $display("test pm done");
  endtask

  // PWM on a pulse carrier, and no PWM on any other carrier.
  task automatic t_pwm();
    apply_reset();
    wr(fmpm_pkg::FMPM_PULSE_HI_OFS, 32'h0000_0000);
    wr(fmpm_pkg::FMPM_PWM_DEV_OFS, 32'h0000_0100);
    mod_case(3'h3, 2'h2, 1'b1, 16'sh4000, 16'sh0, 16'h0001);
    mod_case(3'h3, 2'h2, 1'b1, 16'shC000, 16'sh0, 16'h0000);
    mod_case(3'h3, 2'h2, 1'b0, 16'sh4000, 16'sh0, 16'h0000);
    $display("test pwm done");
  endtask

  // Keying from the trigger level, and a steady carrier with no keying.
  task automatic t_ask();
    mod_case(3'h4, 2'h2, 1'b0, 16'sh0001, 16'sh0, 16'h0001);
    mod_case(3'h4, 2'h2, 1'b0, 16'sh0, 16'sh0, 16'h0000);
    mod_case(3'h0, 2'h2, 1'b0, 16'sh0, 16'sh0, 16'h0001);
    $display("test ask done");
  endtask

  // Main sequence: release reset, then run every scenario in turn.
  initial begin
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_fifo();
    t_fm();
    t_pm();
    t_pwm();
    t_ask();
    t_key();
    final_report();
  end
endmodule // fmpm_core_bench

// ==== bench/fmpm_core_sva.sv ====
/*
  Checker of the modulation core's bus and sample stream ports.
  Assumes it is bound into the core and sees only the core's ports.
*/
`timescale 1ns/100ps
module fmpm_core_sva (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic samp_valid_o,
  input wire logic samp_ready_i,
  input wire fmpm_pkg::fmpm_sample_s samp_data_o
);
  // ---------------------------------------------------------------------
  // Properties.
  // ---------------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  // A read address phase that the slave takes at this edge.
  logic rd_take;
  assign rd_take = hsel_i && htrans_i[1] && hready_i && ce_i && !hwrite_i;

  // Steps of a read beyond the map and of a stalled sample.
  sequence s_far_rd;
    rd_take && (haddr_i > fmpm_pkg::FMPM_STATUS_OFS);
  endsequence
  sequence s_held;
    samp_valid_o && !samp_ready_i;
  endsequence

  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  a_ready_ce: assert property (hreadyout_o == ce_i)
    else $error("hreadyout differs from clock enable");
  a_reset_empty: assert property ($rose(resetn_i) |-> !samp_valid_o)
    else $error("sample valid straight after reset");
  a_valid_start: assert property ($rose(resetn_i) && ce_i |->
    ##[1:2] samp_valid_o) else $error("first sample late");
  a_data_hold: assert property (s_held |=> samp_valid_o &&
    $stable(samp_data_o)) else $error("stalled sample changed");
  a_ce_freeze: assert property (!ce_i |=> $stable(samp_valid_o) &&
    $stable(samp_data_o)) else $error("stream moved while frozen");
  a_rdata_hold: assert property (!rd_take |=> $stable(hrdata_o))
    else $error("read data changed without a read");
  a_far_zero: assert property (s_far_rd |=> hrdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_stream_steady: assert property (samp_valid_o && samp_ready_i && ce_i
    |=> samp_valid_o) else $error("stream ran dry while draining");
endmodule // fmpm_core_sva

bind fmpm_core fmpm_core_sva fmpm_core_sva_inst (
  .mclk_i(mclk_i),
  .resetn_i(resetn_i),
  .ce_i(ce_i),
  .hsel_i(hsel_i),
  .haddr_i(haddr_i),
  .htrans_i(htrans_i),
  .hwrite_i(hwrite_i),
  .hready_i(hready_i),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .hrdata_o(hrdata_o),
  .samp_valid_o(samp_valid_o),
  .samp_ready_i(samp_ready_i),
  .samp_data_o(samp_data_o)
);

// ==== bench/fmpm_src_model.sv ====
/*
  Model of the modulation source and sample sink beside the core.
  Assumes the bench sets the wanted levels just after a rising edge.
*/
`timescale 1ns/100ps
module fmpm_src_model (
  input wire logic mclk_i,
  input wire logic stall_i,
  input wire logic signed [15:0] ext_set_i,
  input wire logic signed [15:0] chan_set_i,
  input wire logic key_set_i,
  output logic signed [15:0] ext_mod_o,
  output logic signed [15:0] chan_mod_o,
  output logic trig_o,
  output logic samp_ready_o
);
  // ---------------------------------------------------------------------
  // Source and sink.
  // ---------------------------------------------------------------------
  // Levels follow the settings one edge late; a stall holds the sink off.
  // Before the first edge the core is still held in reset.
  always @(posedge mclk_i) begin
    ext_mod_o <= ext_set_i;
    chan_mod_o <= chan_set_i;
    trig_o <= key_set_i;
    samp_ready_o <= !stall_i;
  end
endmodule // fmpm_src_model

// ==== design/fmpm_core.sv ====
/*
  Modulation core (FM, PM, PWM, ASK) with its AHB-Lite register slave and
  an output sample FIFO. Assumes one clock mclk_i, an asynchronous active
  low reset, synchronous inputs and a single-slave AHB-Lite bus.
*/
`timescale 1ns/100ps

// -----------------------------------------------------------------------
// Sample FIFO.
// -----------------------------------------------------------------------
module fmpm_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths that the pointer wrap cannot serve.
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
    $error("fmpm_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_st_s;

  fifo_st_s st_q;
  fifo_st_s st_d;
  logic push;
  logic pop;

  // Handshakes are honest: full refuses, empty shows no valid.
  assign in_ready_o = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_q.cnt != '0);
  assign out_data_o = st_q.mem[st_q.rd];
  assign count_o = st_q.cnt;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Next state of storage and pointers.
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data_i;
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end
endmodule // fmpm_fifo

// -----------------------------------------------------------------------
// Modulation core top.
// -----------------------------------------------------------------------
// Function
// RL1: FM moves carrier frequency with the modulating amplitude.
// RL2: FM frequency stays within carrier plus or minus the set deviation.
// RL3: Internal or channel FM uses the programmed frequency deviation.
// RL4: External FM full scale gives exactly the programmed deviation.
// RL5: PM offsets carrier phase with the modulating amplitude.
// RL6: PM offset stays within plus or minus the set phase deviation.
// RL7: Internal or channel PM uses the programmed phase deviation.
// RL8: External PM full scale gives exactly the programmed deviation.
// RL9: PWM acts only when the carrier is a pulse.
// RL10: PWM varies pulse high-time with the modulating amplitude.
// RL11: Largest high-time change equals the set width deviation.
// RL12: External PWM full scale maps to the programmed width deviation.
// RL13: ASK passes carrier on one state, suppresses it on the other.
// RL14: Internal keying toggles at twice the programmed keying rate.
// RL15: External keying follows the trigger input level.
// RL16: Internal source shape and rate programmable; others from signal.
// RL17: External deviation scales linearly with input amplitude.
// RL18: The other channel can modulate directly without external input.
// RL19: Modulating value is signed, normalised to plus or minus full scale.
module fmpm_core #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic signed [15:0] ext_mod_i,
  input wire logic signed [15:0] chan_mod_i,
  input wire logic trig_i,
  output logic samp_valid_o,
  input wire logic samp_ready_i,
  output fmpm_pkg::fmpm_sample_s samp_data_o
);
  localparam int SW = $bits(fmpm_pkg::fmpm_sample_s);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  if (CW > 16) begin : g_bad_depth
    $error("fmpm_core: FIFO_DEPTH too large for the status register");
  end

  // All state of the core outside the sample FIFO in one struct.
  typedef struct packed {
    logic [8:0] ctrl;
    logic [31:0] car_inc;
    logic [31:0] pulse_hi;
    logic [31:0] fm_dev;
    logic [31:0] pm_dev;
    logic [31:0] pwm_dev;
    logic [31:0] mod_inc;
    logic [31:0] key_inc;
    logic [31:0] car_acc;
    logic [31:0] mod_acc;
    logic [31:0] key_acc;
    logic key;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
  } core_st_s;

  core_st_s st_q;
  core_st_s st_d;

  // Scale a deviation by a normalised modulating value; linear in m.
  function automatic logic signed [32:0] scale_dev(
    input logic [31:0] dev,
    input logic signed [15:0] m
  );
    logic signed [48:0] prod;
    prod = $signed({1'b0, dev}) * m;
    scale_dev = prod[46:14]; // [RL17]
  endfunction

  // Clamp an input sample to the normalised full-scale range.
  function automatic logic signed [15:0] clamp_fs(
    input logic signed [15:0] v
  );
    if (v > fmpm_pkg::FMPM_MOD_FS) begin
      clamp_fs = fmpm_pkg::FMPM_MOD_FS;
    end else if (v < -fmpm_pkg::FMPM_MOD_FS) begin
      clamp_fs = -fmpm_pkg::FMPM_MOD_FS;
    end else begin
      clamp_fs = v;
    end
  endfunction

  // ---------------------------------------------------------------------
  // Control field decode.
  // ---------------------------------------------------------------------
  logic en;
  fmpm_pkg::fmpm_type_e mtype;
  fmpm_pkg::fmpm_src_e src;
  fmpm_pkg::fmpm_shape_e shape;
  logic car_is_pulse;

  assign en = st_q.ctrl[fmpm_pkg::FMPM_CTRL_EN_POS];
  assign mtype = fmpm_pkg::fmpm_type_e'(
    st_q.ctrl[fmpm_pkg::FMPM_CTRL_TYPE_POS +: 3]);
  assign src = fmpm_pkg::fmpm_src_e'(
    st_q.ctrl[fmpm_pkg::FMPM_CTRL_SRC_POS +: 2]);
  assign shape = fmpm_pkg::fmpm_shape_e'(
    st_q.ctrl[fmpm_pkg::FMPM_CTRL_SHAPE_POS +: 2]);
  assign car_is_pulse = st_q.ctrl[fmpm_pkg::FMPM_CTRL_PULSE_POS];

  // ---------------------------------------------------------------------
  // Modulating value.
  // ---------------------------------------------------------------------
  logic [15:0] mph;
  logic signed [15:0] int_mod;
  logic signed [15:0] mod_val;

  assign mph = st_q.mod_acc[31:16];

  // Internal generator: shape and rate come from the registers.
  always_comb begin
    unique case (shape)
      fmpm_pkg::FMPM_SHAPE_RAMP_UP: begin
        int_mod = $signed({1'b0, mph[15:1]}) - fmpm_pkg::FMPM_MOD_FS;
      end
      fmpm_pkg::FMPM_SHAPE_RAMP_DN: begin
        int_mod = fmpm_pkg::FMPM_MOD_FS - $signed({1'b0, mph[15:1]});
      end
      fmpm_pkg::FMPM_SHAPE_TRI: begin
        if (!mph[15]) begin
          int_mod = $signed({1'b0, mph[14:0]}) - fmpm_pkg::FMPM_MOD_FS;
        end else begin
          int_mod = fmpm_pkg::FMPM_MOD_FS - $signed({1'b0, mph[14:0]});
        end
      end
      fmpm_pkg::FMPM_SHAPE_SQUARE: begin
        int_mod = mph[15] ? -fmpm_pkg::FMPM_MOD_FS
                          : fmpm_pkg::FMPM_MOD_FS;
      end
    endcase
  end

  // Source select; every source value is clamped to plus or minus full scale.
  always_comb begin
    unique case (src)
      fmpm_pkg::FMPM_SRC_INT: mod_val = clamp_fs(int_mod); // [RL16] [RL19]
      fmpm_pkg::FMPM_SRC_CHAN: mod_val = clamp_fs(chan_mod_i); // [RL18]
      fmpm_pkg::FMPM_SRC_EXT: mod_val = clamp_fs(ext_mod_i); // [RL16]
      default: mod_val = '0;
    endcase
  end

  // ---------------------------------------------------------------------
  // Carrier, phase, pulse and keying datapath.
  // ---------------------------------------------------------------------
  logic signed [32:0] fm_term;
  logic signed [32:0] pm_term;
  logic signed [32:0] pwm_term;
  logic signed [33:0] hi_mod;
  logic [31:0] hi_eff;
  logic [31:0] car_step;
  logic [31:0] out_phase;
  logic [32:0] key_sum;
  logic key_now;
  logic gen_ready;
  logic gen_fire;
  fmpm_pkg::fmpm_sample_s gen_samp;
  logic [CW-1:0] fifo_cnt;
  logic [SW-1:0] fifo_out;

  // Deviations are the programmed values for every source; full scale
  // of any source lands exactly on them.
  assign fm_term = scale_dev(st_q.fm_dev, mod_val); // [RL3] [RL4]
  assign pm_term = scale_dev(st_q.pm_dev, mod_val); // [RL7] [RL8]
  assign pwm_term = scale_dev(st_q.pwm_dev, mod_val); // [RL12]

  // Frequency: carrier step plus the scaled deviation.
  always_comb begin
    if (en && mtype == fmpm_pkg::FMPM_TYPE_FM) begin
      car_step = st_q.car_inc + fm_term[31:0]; // [RL1] [RL2]
    end else begin
      car_step = st_q.car_inc;
    end
  end

  // Phase: unmodulated phase plus the scaled phase deviation.
  always_comb begin
    if (en && mtype == fmpm_pkg::FMPM_TYPE_PM) begin
      out_phase = st_q.car_acc + pm_term[31:0]; // [RL5] [RL6]
    end else begin
      out_phase = st_q.car_acc;
    end
  end

  // High-time: only a pulse carrier is width modulated; clamp at limits.
  always_comb begin
    hi_mod = $signed({2'b00, st_q.pulse_hi}) + 34'(pwm_term); // [RL10]
    if (!(en && mtype == fmpm_pkg::FMPM_TYPE_PWM && car_is_pulse)) begin
      hi_eff = st_q.pulse_hi; // [RL9]
    end else if (hi_mod < 0) begin
      hi_eff = 32'h0000_0000;
    end else if (hi_mod[33:32] != 2'b00) begin
      hi_eff = 32'hFFFF_FFFF;
    end else begin
      hi_eff = hi_mod[31:0]; // [RL11]
    end
  end

  // Keying: internal toggle at twice the rate, or the trigger level.
  assign key_sum = {1'b0, st_q.key_acc} + {st_q.key_inc, 1'b0}; // [RL14]
  assign key_now = (src == fmpm_pkg::FMPM_SRC_EXT) ? trig_i // [RL15]
                                                   : st_q.key;

  // Sample assembly.
  always_comb begin
    gen_samp.phase = out_phase[31:16];
    gen_samp.pulse = (st_q.car_acc < hi_eff);
    if (en && mtype == fmpm_pkg::FMPM_TYPE_ASK) begin
      gen_samp.amp_on = key_now; // [RL13]
    end else begin
      gen_samp.amp_on = 1'b1;
    end
  end

  // The generator advances only when the FIFO takes a sample.
  assign gen_fire = gen_ready;

  fmpm_fifo #(
    .WIDTH(SW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .in_valid_i(1'b1),
    .in_ready_o(gen_ready),
    .in_data_i(gen_samp),
    .out_valid_o(samp_valid_o),
    .out_ready_i(samp_ready_i),
    .out_data_o(fifo_out),
    .count_o(fifo_cnt)
  );

  assign samp_data_o = fmpm_pkg::fmpm_sample_s'(fifo_out);

  // ---------------------------------------------------------------------
  // AHB-Lite slave.
  // ---------------------------------------------------------------------
  logic aph_valid;
  logic [31:0] rd_mux;

  // Zero wait states; held off only while the clock enable is low.
  assign hreadyout_o = ce_i;
  assign hresp_o = 1'b0;
  assign hrdata_o = st_q.rdata;
  assign aph_valid = hsel_i && htrans_i[1] && hready_i;

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr_i)
      fmpm_pkg::FMPM_CTRL_OFS: rd_mux = {23'h000000, st_q.ctrl};
      fmpm_pkg::FMPM_CAR_INC_OFS: rd_mux = st_q.car_inc;
      fmpm_pkg::FMPM_PULSE_HI_OFS: rd_mux = st_q.pulse_hi;
      fmpm_pkg::FMPM_FM_DEV_OFS: rd_mux = st_q.fm_dev;
      fmpm_pkg::FMPM_PM_DEV_OFS: rd_mux = st_q.pm_dev;
      fmpm_pkg::FMPM_PWM_DEV_OFS: rd_mux = st_q.pwm_dev;
      fmpm_pkg::FMPM_MOD_INC_OFS: rd_mux = st_q.mod_inc;
      fmpm_pkg::FMPM_KEY_INC_OFS: rd_mux = st_q.key_inc;
      fmpm_pkg::FMPM_STATUS_OFS: begin
        rd_mux[15:0] = 16'(fifo_cnt);
        rd_mux[16] = key_now;
        rd_mux[17] = gen_samp.pulse;
        rd_mux[18] = gen_samp.amp_on;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------------
  // Next state.
  // ---------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Address phase: capture the write target and the read data.
    st_d.dph_wr = aph_valid && hwrite_i;
    if (aph_valid) begin
      st_d.dph_addr = haddr_i;
      if (!hwrite_i) begin
        st_d.rdata = rd_mux;
      end
    end
    // Data phase of a write: store into the addressed register.
    if (st_q.dph_wr) begin
      unique case (st_q.dph_addr)
        fmpm_pkg::FMPM_CTRL_OFS: st_d.ctrl = hwdata_i[8:0];
        fmpm_pkg::FMPM_CAR_INC_OFS: st_d.car_inc = hwdata_i;
        fmpm_pkg::FMPM_PULSE_HI_OFS: st_d.pulse_hi = hwdata_i;
        fmpm_pkg::FMPM_FM_DEV_OFS: st_d.fm_dev = hwdata_i; // [RL3]
        fmpm_pkg::FMPM_PM_DEV_OFS: st_d.pm_dev = hwdata_i; // [RL7]
        fmpm_pkg::FMPM_PWM_DEV_OFS: st_d.pwm_dev = hwdata_i; // [RL12]
        fmpm_pkg::FMPM_MOD_INC_OFS: st_d.mod_inc = hwdata_i; // [RL16]
        fmpm_pkg::FMPM_KEY_INC_OFS: st_d.key_inc = hwdata_i; // [RL14]
        default: ;
      endcase
    end
    // Generator step, stalled by a full FIFO.
    if (gen_fire) begin
      st_d.car_acc = st_q.car_acc + car_step; // [RL1]
      st_d.mod_acc = st_q.mod_acc + st_q.mod_inc;
      st_d.key_acc = key_sum[31:0];
      if (key_sum[32]) begin
        st_d.key = ~st_q.key; // [RL14]
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '0;
      st_q.ctrl <= fmpm_pkg::FMPM_CTRL_RST;
      st_q.pulse_hi <= fmpm_pkg::FMPM_PULSE_HI_RST;
      st_q.car_inc <= fmpm_pkg::FMPM_WORD_RST;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end
endmodule // fmpm_core

// ==== design/fmpm_pkg.sv ====
/*
  Package of the modulation core: register map, control field positions,
  reset values, modulation type and source codes, and the sample struct.
  Assumes a 32-bit AHB-Lite register bus and one 200 MHz sample clock.
*/
package fmpm_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets.
  // ---------------------------------------------------------------------
  localparam logic [7:0] FMPM_CTRL_OFS = 8'h00;
  localparam logic [7:0] FMPM_CAR_INC_OFS = 8'h04;
  localparam logic [7:0] FMPM_PULSE_HI_OFS = 8'h08;
  localparam logic [7:0] FMPM_FM_DEV_OFS = 8'h0C;
  localparam logic [7:0] FMPM_PM_DEV_OFS = 8'h10;
  localparam logic [7:0] FMPM_PWM_DEV_OFS = 8'h14;
  localparam logic [7:0] FMPM_MOD_INC_OFS = 8'h18;
  localparam logic [7:0] FMPM_KEY_INC_OFS = 8'h1C;
  localparam logic [7:0] FMPM_STATUS_OFS = 8'h20;

  // ---------------------------------------------------------------------
  // Control register fields and reset values.
  // ---------------------------------------------------------------------
  localparam int FMPM_CTRL_EN_POS = 0;
  localparam int FMPM_CTRL_TYPE_POS = 1;
  localparam int FMPM_CTRL_SRC_POS = 4;
  localparam int FMPM_CTRL_SHAPE_POS = 6;
  localparam int FMPM_CTRL_PULSE_POS = 8;
  localparam logic [8:0] FMPM_CTRL_RST = 9'h000;
  localparam logic [31:0] FMPM_WORD_RST = 32'h0000_0000;
  localparam logic [31:0] FMPM_PULSE_HI_RST = 32'h8000_0000;

  // Full-scale magnitude of the normalised modulating value.
  localparam logic signed [15:0] FMPM_MOD_FS = 16'sh4000;
  localparam int FMPM_MOD_FS_SHIFT = 14;

  // ---------------------------------------------------------------------
  // Modes.
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    FMPM_TYPE_NONE = 3'b000,
    FMPM_TYPE_FM = 3'b001,
    FMPM_TYPE_PM = 3'b010,
    FMPM_TYPE_PWM = 3'b011,
    FMPM_TYPE_ASK = 3'b100
  } fmpm_type_e;

  typedef enum logic [1:0] {
    FMPM_SRC_INT = 2'b00,
    FMPM_SRC_CHAN = 2'b01,
    FMPM_SRC_EXT = 2'b10
  } fmpm_src_e;

  typedef enum logic [1:0] {
    FMPM_SHAPE_RAMP_UP = 2'b00,
    FMPM_SHAPE_RAMP_DN = 2'b01,
    FMPM_SHAPE_TRI = 2'b10,
    FMPM_SHAPE_SQUARE = 2'b11
  } fmpm_shape_e;

  // One output sample: carrier phase, pulse level and amplitude gate.
  typedef struct packed {
    logic [15:0] phase;
    logic pulse;
    logic amp_on;
  } fmpm_sample_s;

endpackage
